// [core/cfj_judge.sv]
// Comparator and fault judge with AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cfj_consts.svh"
module cfj_judge import cfj_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cfj_meas_s meas,
  input wire logic meas_done,
  output cfj_res_e comp_result_r,
  output cfj_disp_e display_r,
  output logic error_line_r,
  output logic contact_fault_high_side_r,
  output logic contact_fault_low_side_r,
  output logic above_range_indication_r,
  output logic below_range_indication_r
);
  // ==================================================================
  // Register bus
  logic aw_held_r, w_held_r;
  logic [3:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] rdata_nxt;
  wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [3:0] ar_idx = s_axi_araddr[5:2];
  wire ar_hit = s_axi_araddr[31:6] == 26'h0 && ar_idx <= `CFJ_A_CMD;
  wire w_hit = aw_idx_r <= `CFJ_A_CMD;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[31:6] == 26'h0 ? s_axi_awaddr[5:2] : 4'hF;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Ready flags registered from next state: same timing as a decode
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire b_done = s_axi_bvalid && s_axi_bready;
  wire r_done = s_axi_rvalid && s_axi_rready;
  wire bvalid_nxt = do_write || (s_axi_bvalid && !b_done);
  wire aw_held_nxt = !do_write && (aw_held_r || aw_take);
  wire w_held_nxt = !do_write && (w_held_r || w_take);
  wire rvalid_nxt = ar_take || (s_axi_rvalid && !r_done);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
      s_axi_wready <= !w_held_nxt && !bvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
    end
  end
  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) m[i*8 +: 8] = nw[i*8 +: 8];
    end
    return m;
  endfunction
  // ==================================================================
  // Staged settings: entry edits a shadow, commit copies it, abort drops
  cfj_cfg_s act_r, stg_r;
  logic settings_changed_r;
  wire [31:0] wmerged_ctrl = merge({29'h0, stg_r.wide, stg_r.abs_mode,
                                    stg_r.enable}, wdata_r, wstrb_r);
  wire [31:0] wm_ref = merge(stg_r.ref_val, wdata_r, wstrb_r);
  wire [31:0] wm_up = merge(stg_r.upper, wdata_r, wstrb_r);
  wire [31:0] wm_lo = merge(stg_r.lower, wdata_r, wstrb_r);
  wire [31:0] wm_tp = merge(stg_r.tol_pos, wdata_r, wstrb_r);
  wire [31:0] wm_tn = merge(stg_r.tol_neg, wdata_r, wstrb_r);
  wire [31:0] wm_cl = merge(stg_r.contact_limit, wdata_r, wstrb_r);
  // Tolerance accepted only within +/-9999 counts of its scale
  wire tp_ok = $signed(wm_tp) <= $signed(`CFJ_TOL_MAX) &&
               $signed(wm_tp) >= -$signed(`CFJ_TOL_MAX); // [R2]
  wire tn_ok = $signed(wm_tn) <= $signed(`CFJ_TOL_MAX) &&
               $signed(wm_tn) >= -$signed(`CFJ_TOL_MAX); // [R2]
  wire wr_cmd = do_write && aw_idx_r == `CFJ_A_CMD;
  wire commit = wr_cmd && wdata_r[`CFJ_CMD_COMMIT];
  wire abort = wr_cmd && wdata_r[`CFJ_CMD_ABORT] &&
               !wdata_r[`CFJ_CMD_COMMIT];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_r <= '{enable: 1'b1, abs_mode: 1'b0, wide: 1'b0,
                 ref_val: 32'h0, upper: 32'h0, lower: 32'h0,
                 tol_pos: 32'h0, tol_neg: 32'h0,
                 contact_limit: `CFJ_CLIM_RST}; // [R1]
      stg_r <= '{enable: 1'b1, abs_mode: 1'b0, wide: 1'b0,
                 ref_val: 32'h0, upper: 32'h0, lower: 32'h0,
                 tol_pos: 32'h0, tol_neg: 32'h0,
                 contact_limit: `CFJ_CLIM_RST};
      settings_changed_r <= 1'b0;
    end else begin
      settings_changed_r <= 1'b0;
      if (commit) begin
        act_r <= stg_r;
        settings_changed_r <= 1'b1;
      end else if (abort) begin
        stg_r <= act_r; // [R14]
      end else if (do_write) begin
        unique case (aw_idx_r)
          `CFJ_A_CTRL: begin
            stg_r.enable <= wmerged_ctrl[`CFJ_CTRL_EN];
            stg_r.abs_mode <= wmerged_ctrl[`CFJ_CTRL_ABS];
            stg_r.wide <= wmerged_ctrl[`CFJ_CTRL_WIDE];
          end
          `CFJ_A_REF: stg_r.ref_val <= wm_ref;
          `CFJ_A_UPPER: stg_r.upper <= wm_up;
          `CFJ_A_LOWER: stg_r.lower <= wm_lo;
          `CFJ_A_TPOS: begin
            if (tp_ok) begin
              stg_r.tol_pos <= wm_tp;
              stg_r.tol_neg <= -$signed(wm_tp); // [R3]
            end
          end
          `CFJ_A_TNEG: begin
            if (tn_ok) stg_r.tol_neg <= wm_tn;
          end
          `CFJ_A_CLIM: stg_r.contact_limit <= wm_cl;
          default: ;
        endcase
      end
    end
  end
  // ==================================================================
  // Judgment
  // Deviation scaled to 0.001% (narrow) or 0.01% (wide) units
  wire [63:0] scale = act_r.wide ? `CFJ_SCALE_WIDE : `CFJ_SCALE_NARROW;
  wire signed [64:0] diff = $signed({33'h0, meas.value}) -
                            $signed({33'h0, act_r.ref_val});
  wire signed [64:0] lhs = 65'(diff * $signed({1'b0, scale}));
  wire signed [64:0] ref_ext = $signed({33'h0, act_r.ref_val});
  wire signed [64:0] hi_bound = 65'(ref_ext * 65'(act_r.tol_pos));
  wire signed [64:0] lo_bound = 65'(ref_ext * 65'(act_r.tol_neg));
  // Compare without a divider: dev*scale against tol*ref
  wire rel_hi = lhs > hi_bound; // [R18]
  wire rel_lo = lhs < lo_bound; // [R18]
  wire abs_hi = meas.value > act_r.upper; // [R17]
  wire abs_lo = meas.value < act_r.lower; // [R17]
  wire j_hi = act_r.abs_mode ? abs_hi : rel_hi;
  wire j_lo = act_r.abs_mode ? abs_lo : rel_lo;
  cfj_res_e value_res;
  assign value_res = j_hi ? CFJ_HI : (j_lo ? CFJ_LO : CFJ_IN);
  // Fault checks, in priority order
  wire ce_hi = meas.contact_hi_res >= act_r.contact_limit; // [R7]
  wire ce_lo = meas.contact_lo_res >= act_r.contact_limit; // [R7]
  wire ce_volt = meas.volt_unstable; // [R8]
  wire cur_flt = meas.current_fail;
  wire above = meas.above_range || (cur_flt && !meas.below_range);
  wire below = meas.below_range && !meas.above_range;
  cfj_disp_e disp_nxt;
  cfj_res_e res_nxt;
  logic err_nxt;
  always_comb begin
    disp_nxt = CFJ_SHOW_VALUE;
    res_nxt = act_r.enable ? value_res : CFJ_NONE; // [R1] [R9]
    err_nxt = 1'b0;
    if (ce_hi) begin // [R13]
      disp_nxt = CFJ_SHOW_CE_HI;
      res_nxt = CFJ_NONE; // [R11] [R16]
      err_nxt = 1'b1; // [R4]
    end else if (ce_lo) begin
      disp_nxt = CFJ_SHOW_CE_LO;
      res_nxt = CFJ_NONE; // [R11]
      err_nxt = 1'b1; // [R11]
    end else if (ce_volt) begin
      disp_nxt = CFJ_SHOW_CE_VOLT;
      res_nxt = CFJ_NONE; // [R11]
      err_nxt = 1'b1; // [R11]
    end else if (above) begin
      disp_nxt = CFJ_SHOW_ABOVE; // [R10] [R15]
      res_nxt = act_r.enable ? CFJ_HI : CFJ_NONE; // [R5] [R6]
    end else if (below) begin
      disp_nxt = CFJ_SHOW_BELOW; // [R10]
      res_nxt = act_r.enable ? CFJ_LO : CFJ_NONE; // [R5] [R6]
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      display_r <= CFJ_SHOW_HOLD;
      comp_result_r <= CFJ_NONE;
      error_line_r <= 1'b0;
      contact_fault_high_side_r <= 1'b0;
      contact_fault_low_side_r <= 1'b0;
      above_range_indication_r <= 1'b0;
      below_range_indication_r <= 1'b0;
    end else if (meas_done) begin
      display_r <= disp_nxt;
      comp_result_r <= res_nxt;
      error_line_r <= err_nxt;
      contact_fault_high_side_r <= disp_nxt == CFJ_SHOW_CE_HI;
      contact_fault_low_side_r <= disp_nxt == CFJ_SHOW_CE_LO;
      above_range_indication_r <= disp_nxt == CFJ_SHOW_ABOVE;
      below_range_indication_r <= disp_nxt == CFJ_SHOW_BELOW;
    end else if (settings_changed_r) begin
      display_r <= CFJ_SHOW_HOLD; // [R12]
      comp_result_r <= CFJ_NONE;
    end
  end
  // ==================================================================
  // Read path
  always_comb begin
    rdata_nxt = 32'h0;
    unique case (ar_idx)
      `CFJ_A_CTRL: rdata_nxt = {29'h0, stg_r.wide, stg_r.abs_mode,
                                stg_r.enable};
      `CFJ_A_REF: rdata_nxt = stg_r.ref_val;
      `CFJ_A_UPPER: rdata_nxt = stg_r.upper;
      `CFJ_A_LOWER: rdata_nxt = stg_r.lower;
      `CFJ_A_TPOS: rdata_nxt = stg_r.tol_pos;
      `CFJ_A_TNEG: rdata_nxt = stg_r.tol_neg;
      `CFJ_A_CLIM: rdata_nxt = stg_r.contact_limit;
      `CFJ_A_STAT: rdata_nxt = {22'h0, error_line_r, display_r,
                                 below_range_indication_r,
                                 above_range_indication_r,
                                 contact_fault_low_side_r,
                                 contact_fault_high_side_r,
                                 comp_result_r};
      default: rdata_nxt = 32'h0;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= ar_hit ? rdata_nxt : 32'h0;
      s_axi_rresp <= ar_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ==================================================================
  // Checks
  // Measurement with no fault of any kind
  wire meas_clean = !ce_hi && !ce_lo && !ce_volt && !above && !below;
  out_range_err_a: assert property (@(posedge clk) disable iff (!rstn) // [R6]
    above_range_indication_r || below_range_indication_r |-> !error_line_r)
    else $error("error line high during out-of-range");
  contact_err_a: assert property (@(posedge clk) disable iff (!rstn) // [R11]
    meas_done && (ce_hi || ce_lo || ce_volt) |=>
    error_line_r && comp_result_r == CFJ_NONE)
    else $error("contact fault missed error or judged");
  above_hi_a: assert property (@(posedge clk) disable iff (!rstn) // [R15]
    meas_done && !ce_hi && !ce_lo && !ce_volt && cur_flt &&
    !meas.below_range && act_r.enable |=> comp_result_r == CFJ_HI &&
    above_range_indication_r)
    else $error("current fault not reported high");
  neg_preload_a: assert property (@(posedge clk) disable iff (!rstn) // [R3]
    do_write && aw_idx_r == `CFJ_A_TPOS && tp_ok && !commit && !abort |=>
    stg_r.tol_neg == -$signed($past(wm_tp)))
    else $error("negative tolerance not preloaded");
  abort_keep_a: assert property (@(posedge clk) disable iff (!rstn) // [R14]
    abort |=> stg_r == $past(act_r) && act_r == $past(act_r))
    else $error("abort did not restore settings");
  hold_disp_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    settings_changed_r && !meas_done |=> display_r == CFJ_SHOW_HOLD)
    else $error("settings change did not hold display");
  disabled_none_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
    meas_done && !act_r.enable |=> comp_result_r == CFJ_NONE)
    else $error("judgment made while disabled");
  first_fault_a: assert property (@(posedge clk) disable iff (!rstn) // [R13]
    meas_done && ce_hi && ce_lo |=> contact_fault_high_side_r &&
    !contact_fault_low_side_r)
    else $error("fault order not kept");
  tol_reject_a: assert property (@(posedge clk) disable iff (!rstn) // [R2]
    do_write && aw_idx_r == `CFJ_A_TPOS && !tp_ok |=>
    stg_r.tol_pos == $past(stg_r.tol_pos) &&
    stg_r.tol_neg == $past(stg_r.tol_neg))
    else $error("out-of-range tolerance accepted");
  volt_fault_a: assert property (@(posedge clk) disable iff (!rstn) // [R8]
    meas_done && !ce_hi && !ce_lo && meas.volt_unstable |=>
    display_r == CFJ_SHOW_CE_VOLT && error_line_r)
    else $error("unstable sense voltage not flagged");
  below_low_a: assert property (@(posedge clk) disable iff (!rstn) // [R5]
    meas_done && !ce_hi && !ce_lo && !ce_volt && meas.below_range &&
    !meas.above_range && act_r.enable |=> comp_result_r == CFJ_LO &&
    below_range_indication_r && !error_line_r)
    else $error("below range not reported low");
  ce_low_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
    meas_done && !ce_hi && meas.contact_lo_res >= act_r.contact_limit |=>
    contact_fault_low_side_r && display_r == CFJ_SHOW_CE_LO)
    else $error("low side contact fault missed");
  clean_no_err_a: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    meas_done && !ce_hi && !ce_lo && !ce_volt |=> !error_line_r)
    else $error("error line without contact fault");
  value_shown_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
    meas_done && meas_clean |=> display_r == CFJ_SHOW_VALUE)
    else $error("clean measurement not displayed");
  abs_high_a: assert property (@(posedge clk) disable iff (!rstn) // [R17]
    meas_done && meas_clean && act_r.enable && act_r.abs_mode &&
    meas.value > act_r.upper |=> comp_result_r == CFJ_HI)
    else $error("absolute high not reported");
  abs_low_a: assert property (@(posedge clk) disable iff (!rstn) // [R17]
    meas_done && meas_clean && act_r.enable && act_r.abs_mode &&
    meas.value <= act_r.upper && meas.value < act_r.lower |=>
    comp_result_r == CFJ_LO)
    else $error("absolute low not reported");
  abs_in_a: assert property (@(posedge clk) disable iff (!rstn) // [R17]
    meas_done && meas_clean && act_r.enable && act_r.abs_mode &&
    meas.value <= act_r.upper && meas.value >= act_r.lower |=>
    comp_result_r == CFJ_IN)
    else $error("absolute in-range not reported");
endmodule
`default_nettype wire

// [core/cfj_consts.svh]
// Constants: register map, field layout, reset values of the fault judge
// ====================================================================
// Behaviour
// R1: Judgment enabled after reset; when disabled, stored limits are ignored.
// R2: Relative tolerances limited to +/-9999 (0.001%) or +/-9999 (0.01%).
// R3: Accepting positive tolerance preloads negative tolerance with opposite sign.
// R4: Any fault shows indication and raises error line, except out-of-range.
// R5: Above range reports high; below range reports low.
// R6: Error line stays low for above or below range indications.
// R7: Contact fault when contact resistance is at or above its limit.
// R8: Unstable sense voltage raises a voltage-monitor contact fault.
// R9: All monitors pass: show value and judge it.
// R10: Only current monitor fails: out-of-range display with matching result.
// R11: Contact or voltage fault: fault code, no judgment, error line high.
// R12: After a settings change, hold fault display until next measurement.
// R13: Faults checked in fixed order; only the first one is shown.
// R14: Aborted entry session discards entered values, keeps stored settings.
// R15: Current fault with good contacts reports high for range and result.
// R16: No comparator judgment while a measurement fault is present.
// R17: Absolute mode: high above upper, low below lower, else in range.
// R18: Relative mode: deviation is (value-ref)/ref*100, against both limits.
`ifndef CFJ_CONSTS_SVH
`define CFJ_CONSTS_SVH
`define CFJ_A_CTRL 4'h0
`define CFJ_A_REF 4'h1
`define CFJ_A_UPPER 4'h2
`define CFJ_A_LOWER 4'h3
`define CFJ_A_TPOS 4'h4
`define CFJ_A_TNEG 4'h5
`define CFJ_A_CLIM 4'h6
`define CFJ_A_STAT 4'h7
`define CFJ_A_CMD 4'h8
`define CFJ_CTRL_EN 0
`define CFJ_CTRL_ABS 1
`define CFJ_CTRL_WIDE 2
`define CFJ_CMD_COMMIT 0
`define CFJ_CMD_ABORT 1
`define CFJ_CTRL_RST 32'h0000_0001
`define CFJ_CLIM_RST 32'hFFFF_FFFF
`define CFJ_TOL_MAX 32'h0000_270F
`define CFJ_SCALE_NARROW 64'h0000_0000_0001_86A0
`define CFJ_SCALE_WIDE 64'h0000_0000_0000_2710
`endif

// [core/cfj_pkg.sv]
// Package: types of the comparator and fault judge
package cfj_pkg;
  typedef enum logic [1:0] {CFJ_NONE, CFJ_HI, CFJ_IN, CFJ_LO} cfj_res_e;
  typedef enum logic [2:0] {
    CFJ_SHOW_VALUE, CFJ_SHOW_ABOVE, CFJ_SHOW_BELOW, CFJ_SHOW_CE_HI,
    CFJ_SHOW_CE_LO, CFJ_SHOW_CE_VOLT, CFJ_SHOW_HOLD
  } cfj_disp_e;
  typedef struct packed {
    logic [31:0] value;
    logic [31:0] contact_hi_res;
    logic [31:0] contact_lo_res;
    logic above_range;
    logic below_range;
    logic volt_unstable;
    logic current_fail;
  } cfj_meas_s;
  typedef struct packed {
    logic enable;
    logic abs_mode;
    logic wide;
    logic [31:0] ref_val;
    logic [31:0] upper;
    logic [31:0] lower;
    logic signed [31:0] tol_pos;
    logic signed [31:0] tol_neg;
    logic [31:0] contact_limit;
  } cfj_cfg_s;
endpackage

// [dv/cfj_meas_src.sv]
// Partner model: measurement front end that reports finished measurements
`timescale 1ns/1ps
`default_nettype none
module cfj_meas_src import cfj_pkg::*; (
  input wire logic clk,
  output var cfj_meas_s meas,
  output logic meas_done
);
  initial begin
    meas = '0;
    meas_done = 1'b0;
  end

  // ==================================================================
  // Frame delivery
  task automatic send(input cfj_meas_s m, input int dly);
    repeat (dly) @(posedge clk);
    meas <= m;
    meas_done <= 1'b1;
    @(posedge clk);
    // Stale data outside a frame must never look like a valid result
    meas <= ~m;
    meas_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Testbench: register access and measurement judgment sequences
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module testbench import cfj_pkg::*;;
  logic clk, rstn, awvalid, wvalid, arvalid, awready, wready, arready;
  logic bvalid, rvalid, meas_done, err, ce_hi, ce_lo, above, below;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp;
  cfj_meas_s meas;
  cfj_res_e res;
  cfj_disp_e disp;
  int bad_count, n_checks, cycles;

  cfj_judge i_dut (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .meas(meas), .meas_done(meas_done), .comp_result_r(res),
    .display_r(disp), .error_line_r(err),
    .contact_fault_high_side_r(ce_hi), .contact_fault_low_side_r(ce_lo),
    .above_range_indication_r(above), .below_range_indication_r(below));

  cfj_meas_src i_src (.clk(clk), .meas(meas), .meas_done(meas_done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==================================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (ap || wp) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      ap = ap && !awready;
      wp = wp && !wready;
    end
    do @(posedge clk); while (!bvalid);
    `CHK("bresp", er, bresp);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    `CHK("read data", e, rdata);
    `CHK("read resp", a < 32'h24 ? 2'h0 : 2'h2, rresp);
  endtask

  // Flags: contact hi/lo at limit, above, below, volt unstable, current
  task automatic mc(input logic [31:0] v, input logic [5:0] f,
                    input int dly, input logic [1:0] r,
                    input logic [2:0] dp, input logic e,
                    input logic [3:0] fl);
    cfj_meas_s m;
    m = '{v, f[5] ? 32'h64 : 32'h63, f[4] ? 32'h64 : 32'h63,
          f[3], f[2], f[1], f[0]};
    i_src.send(m, dly);
    @(posedge clk);
    #1;
    `CHK("result", r, res);
    `CHK("display", dp, disp);
    `CHK("error line", e, err);
    `CHK("flags", fl, {ce_hi, ce_lo, above, below});
    @(posedge clk);
  endtask

  // Generous ceiling: the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      close_out();
    end
  end

  // ==================================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {awaddr, wdata, araddr} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK("reset display", CFJ_SHOW_HOLD, disp);
    `CHK("reset result", CFJ_NONE, res);
    rchk(32'h0, 32'h1);
    mc(32'h5, 6'h00, 0, CFJ_HI, CFJ_SHOW_VALUE, 1'b0, 4'h0);
    wr(32'h4, 32'h3E8, 2'h0);
    wr(32'h10, 32'h1194, 2'h0);
    rchk(32'h14, 32'hFFFF_EE6C);
    wr(32'h10, 32'h2710, 2'h0);
    rchk(32'h10, 32'h1194);
    wr(32'h18, 32'h64, 2'h0);
    wr(32'h20, 32'h1, 2'h0);
    @(posedge clk);
    `CHK("hold display", CFJ_SHOW_HOLD, disp);
    `CHK("hold result", CFJ_NONE, res);
    mc(32'h410, 6'h00, 0, CFJ_IN, CFJ_SHOW_VALUE, 1'b0, 4'h0);
    mc(32'h41A, 6'h00, 0, CFJ_HI, CFJ_SHOW_VALUE, 1'b0, 4'h0);
    mc(32'h3B6, 6'h00, 3, CFJ_LO, CFJ_SHOW_VALUE, 1'b0, 4'h0);
    mc(32'h410, 6'h20, 0, CFJ_NONE, CFJ_SHOW_CE_HI, 1'b1, 4'h8);
    rchk(32'h1C, 32'h2C4);
    mc(32'h410, 6'h10, 0, CFJ_NONE, CFJ_SHOW_CE_LO, 1'b1, 4'h4);
    mc(32'h410, 6'h02, 2, CFJ_NONE, CFJ_SHOW_CE_VOLT, 1'b1, 4'h0);
    mc(32'h410, 6'h23, 0, CFJ_NONE, CFJ_SHOW_CE_HI, 1'b1, 4'h8);
    mc(32'h410, 6'h03, 0, CFJ_NONE, CFJ_SHOW_CE_VOLT, 1'b1, 4'h0);
    mc(32'h410, 6'h01, 0, CFJ_HI, CFJ_SHOW_ABOVE, 1'b0, 4'h2);
    mc(32'h410, 6'h08, 0, CFJ_HI, CFJ_SHOW_ABOVE, 1'b0, 4'h2);
    mc(32'h410, 6'h04, 0, CFJ_LO, CFJ_SHOW_BELOW, 1'b0, 4'h1);
    mc(32'h410, 6'h05, 0, CFJ_LO, CFJ_SHOW_BELOW, 1'b0, 4'h1);
    wr(32'h4, 32'h5, 2'h0);
    wr(32'h20, 32'h2, 2'h0);
    rchk(32'h4, 32'h3E8);
    mc(32'h410, 6'h00, 0, CFJ_IN, CFJ_SHOW_VALUE, 1'b0, 4'h0);
    wr(32'h0, 32'h3, 2'h0);
    wr(32'h8, 32'hC8, 2'h0);
    wr(32'hC, 32'h64, 2'h0);
    wr(32'h20, 32'h1, 2'h0);
    mc(32'hFA, 6'h00, 0, CFJ_HI, CFJ_SHOW_VALUE, 1'b0, 4'h0);
    mc(32'h96, 6'h00, 0, CFJ_IN, CFJ_SHOW_VALUE, 1'b0, 4'h0);
    mc(32'h32, 6'h00, 0, CFJ_LO, CFJ_SHOW_VALUE, 1'b0, 4'h0);
    wr(32'h0, 32'h2, 2'h0);
    wr(32'h20, 32'h1, 2'h0);
    mc(32'h32, 6'h00, 0, CFJ_NONE, CFJ_SHOW_VALUE, 1'b0, 4'h0);
    wr(32'h40, 32'h0, 2'h2);
    rchk(32'h40, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
